//--- logic/pumsa_pkg.sv
// Package with constants for the power-up mode select and autoload block.
package pumsa_pkg;
  // ==========================================================================
  // Register map (word offsets as byte addresses on the Avalon bus).
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_CWORD = 4'h8;
  localparam logic [3:0] OFF_CAL_SEL = 4'hC;
  // ==========================================================================
  // Power-up configuration word fields.
  localparam int PCW_WAIT_LSB = 0;
  localparam int PCW_REP_LSB = 4;
  localparam logic [2:0] REP_FORCE = 3'h7;
  localparam logic [7:0] PCW_FACTORY = 8'h70;
  // ==========================================================================
  // Flash layout, in bytes.
  localparam logic [10:0] FL_PCW_ADDR = 11'h000;
  localparam logic [10:0] FL_CAL_ADDR = 11'h001;
  localparam int NUM_CAL_REGS = 6;
  localparam logic [10:0] FL_SPAN_LUT = 11'h010;
  localparam logic [10:0] FL_OFS_LUT = 11'h170;
  localparam int LUT_ENTRIES = 176;
  // ==========================================================================
  // Control word value and timing.
  localparam logic [7:0] CTRL_WORD = 8'h5A;
  localparam int CLK_HZ = 40_000_000;
  localparam int WAIT_UNIT_US = 10;
  localparam int WAIT_UNIT_CYC = CLK_HZ / 1_000_000 * WAIT_UNIT_US;
  // ==========================================================================
  // Mode and state encodings.
  localparam logic MODE_ANALOG = 1'b0;
  localparam logic MODE_PROG = 1'b1;
  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_LOADCAL = 3'b001,
    ST_WAIT = 3'b010,
    ST_ANALOG = 3'b011,
    ST_PROG = 3'b100
  } pumsa_state_e;
endpackage

//--- logic/pumsa_flash_rd.sv
// Flash read sequencer: one byte read at a time with a fixed latency.
`timescale 1ns/1ps
module pumsa_flash_rd #(
  parameter int LAT = 2
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [10:0] addr,
  input wire logic [7:0] fl_data,
  output logic [10:0] fl_addr,
  output logic done
);
  logic [3:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;
  logic [10:0] addr_r, addr_nxt;
  logic done_r, done_nxt;
  // A request latches the address and counts off the array access time.
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    addr_nxt = addr_r;
    done_nxt = 1'b0;
    if (start && !busy_r) begin
      busy_nxt = 1'b1;
      addr_nxt = addr;
      cnt_nxt = 4'(LAT);
    end else if (busy_r) begin
      if (cnt_r == 4'h0) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      addr_r <= 11'h000;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      addr_r <= addr_nxt;
      done_r <= done_nxt;
    end
  end
  assign fl_addr = addr_r;
  assign done = done_r;
endmodule

//--- logic/pumsa_top.sv
// Power-up mode selection and calibration autoload controller.
`timescale 1ns/1ps
module pumsa_top (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [10:0] FLASH_ADDR,
  input wire logic [7:0] FLASH_DATA,
  input wire logic FLASH_BLANK,
  output logic MODE_PROG,
  output logic LOAD_DONE,
  output logic [15:0] SPAN_DAC_IDX_BASE
);
  pumsa_pkg::pumsa_state_e st_r, st_nxt;
  logic [7:0] pcw_r, pcw_nxt;
  logic [2:0] cal_i_r, cal_i_nxt;
  logic [7:0] cal_r [pumsa_pkg::NUM_CAL_REGS];
  logic [7:0] cal_nxt [pumsa_pkg::NUM_CAL_REGS];
  logic [23:0] wcnt_r, wcnt_nxt;
  logic [2:0] cw_r, cw_nxt;
  logic mode_r, mode_nxt;
  logic done_r, done_nxt;
  logic rd_start_r, rd_start_nxt;
  logic [10:0] rd_addr_r, rd_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wait_r, wait_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic [10:0] fl_addr;
  logic fl_done;
  logic [23:0] wait_limit;
  logic req;
  logic wr_acc;
  logic rd_pend_r, rd_pend_nxt;

  // ==========================================================================
  // Flash reader.
  pumsa_flash_rd #(.LAT(2)) u_rd (
    .clk(REF_CLK),
    .srst(SRST),
    .start(rd_start_r),
    .addr(rd_addr_r),
    .fl_data(FLASH_DATA),
    .fl_addr(fl_addr),
    .done(fl_done)
  );

  // Wait time grows by powers of two of the configured unit; 24 bits hold the longest one.
  assign wait_limit = 24'((24'h00_0001 << pcw_r[3:0]) * pumsa_pkg::WAIT_UNIT_CYC);
  // A request is seen in its first cycle; a write lands only when the answer is given.
  assign req = (AVS_READ || AVS_WRITE) && wait_r;
  assign wr_acc = AVS_WRITE && !wait_r;

  // ==========================================================================
  // Power-up sequence and mode selection.
  // The bus answers one cycle after a request: waitrequest is high for the first cycle.
  always_comb begin
    st_nxt = st_r;
    pcw_nxt = pcw_r;
    cal_i_nxt = cal_i_r;
    cal_nxt = cal_r;
    wcnt_nxt = wcnt_r;
    cw_nxt = cw_r;
    mode_nxt = mode_r;
    done_nxt = done_r;
    rd_start_nxt = 1'b0;
    rd_pend_nxt = rd_pend_r;
    rd_addr_nxt = rd_addr_r;
    rdata_nxt = rdata_r;
    sel_nxt = sel_r;
    wait_nxt = 1'b1;
    case (st_r)
      pumsa_pkg::ST_FETCH: begin
        rd_addr_nxt = pumsa_pkg::FL_PCW_ADDR;
        // One start per byte: a start still high in the done cycle would launch a stray read.
        if (!rd_pend_r) begin
          rd_start_nxt = 1'b1;
          rd_pend_nxt = 1'b1;
        end
        if (fl_done) begin
          rd_pend_nxt = 1'b0;
          // An erased array reads as the factory default that starts in programming mode.
          pcw_nxt = FLASH_BLANK ? pumsa_pkg::PCW_FACTORY : FLASH_DATA;
          st_nxt = pumsa_pkg::ST_LOADCAL;
          cal_i_nxt = 3'h0;
        end
      end
      pumsa_pkg::ST_LOADCAL: begin
        rd_addr_nxt = pumsa_pkg::FL_CAL_ADDR + 11'(cal_i_r);
        if (!rd_pend_r) begin
          rd_start_nxt = 1'b1;
          rd_pend_nxt = 1'b1;
        end
        if (fl_done) begin
          rd_pend_nxt = 1'b0;
          cal_nxt[cal_i_r] = FLASH_DATA;
          if (cal_i_r == 3'(pumsa_pkg::NUM_CAL_REGS - 1)) begin
            done_nxt = 1'b1;
            wcnt_nxt = 24'h00_0000;
            if (pcw_r[pumsa_pkg::PCW_REP_LSB +: 3] == pumsa_pkg::REP_FORCE) begin
              mode_nxt = pumsa_pkg::MODE_PROG;
              st_nxt = pumsa_pkg::ST_PROG;
            end else begin
              st_nxt = pumsa_pkg::ST_WAIT;
            end
          end else begin
            cal_i_nxt = cal_i_r + 3'h1;
          end
        end
      end
      pumsa_pkg::ST_WAIT: begin
        wcnt_nxt = wcnt_r + 24'h00_0001;
        if (cw_r > pcw_r[pumsa_pkg::PCW_REP_LSB +: 3]) begin
          mode_nxt = pumsa_pkg::MODE_PROG;
          st_nxt = pumsa_pkg::ST_PROG;
        end else if (wcnt_r >= wait_limit) begin
          mode_nxt = pumsa_pkg::MODE_ANALOG;
          st_nxt = pumsa_pkg::ST_ANALOG;
        end
      end
      pumsa_pkg::ST_ANALOG: begin
        st_nxt = pumsa_pkg::ST_ANALOG;
      end
      pumsa_pkg::ST_PROG: begin
        st_nxt = pumsa_pkg::ST_PROG;
      end
      default: begin
        st_nxt = pumsa_pkg::ST_FETCH;
      end
    endcase
    // Bus slave: read data is prepared in the request cycle and stands in the answer cycle.
    if (req) begin
      wait_nxt = 1'b0;
      rdata_nxt = 32'h0000_0000;
      if (AVS_READ) begin
        case (AVS_ADDRESS)
          pumsa_pkg::OFF_STATUS: rdata_nxt = {21'h0, done_r, mode_r, cw_r, st_r, 3'h0};
          pumsa_pkg::OFF_CWORD: rdata_nxt = {24'h0, pcw_r};
          pumsa_pkg::OFF_CAL_SEL: begin
            if (sel_r < 3'(pumsa_pkg::NUM_CAL_REGS)) begin
              rdata_nxt = {21'h0, sel_r, cal_r[sel_r]};
            end
          end
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    // Writes land at the edge where the master sees waitrequest low, and at no other.
    if (wr_acc) begin
      case (AVS_ADDRESS)
        pumsa_pkg::OFF_CWORD: begin
          // Counting stops once the choice is made, so late words cannot flip the mode.
          if (st_r == pumsa_pkg::ST_WAIT && AVS_WRITEDATA[7:0] == pumsa_pkg::CTRL_WORD
              && cw_r != 3'h7) begin
            cw_nxt = cw_r + 3'h1;
          end
        end
        pumsa_pkg::OFF_CTRL: begin
          if (st_r == pumsa_pkg::ST_PROG && AVS_WRITEDATA[0]) begin
            mode_nxt = pumsa_pkg::MODE_ANALOG;
            st_nxt = pumsa_pkg::ST_ANALOG;
          end
        end
        pumsa_pkg::OFF_CAL_SEL: begin
          sel_nxt = AVS_WRITEDATA[2:0];
          // Direct calibration writes are refused outside programming mode.
          if (st_r == pumsa_pkg::ST_PROG
              && AVS_WRITEDATA[2:0] < 3'(pumsa_pkg::NUM_CAL_REGS)) begin
            cal_nxt[AVS_WRITEDATA[2:0]] = AVS_WRITEDATA[15:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Every piece of state registers here; reset restarts the power-up flow.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      st_r <= pumsa_pkg::ST_FETCH;
      pcw_r <= 8'h00;
      cal_i_r <= 3'h0;
      for (int i = 0; i < pumsa_pkg::NUM_CAL_REGS; i++) begin
        cal_r[i] <= 8'h00;
      end
      wcnt_r <= 24'h00_0000;
      cw_r <= 3'h0;
      mode_r <= pumsa_pkg::MODE_ANALOG;
      done_r <= 1'b0;
      rd_start_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_addr_r <= 11'h000;
      rdata_r <= 32'h0000_0000;
      wait_r <= 1'b1;
      sel_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      pcw_r <= pcw_nxt;
      cal_i_r <= cal_i_nxt;
      cal_r <= cal_nxt;
      wcnt_r <= wcnt_nxt;
      cw_r <= cw_nxt;
      mode_r <= mode_nxt;
      done_r <= done_nxt;
      rd_start_r <= rd_start_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_addr_r <= rd_addr_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      sel_r <= sel_nxt;
    end
  end

  // Outputs other than the constant table base come from flip-flops; the flash address is registered in the reader.
  assign AVS_READDATA = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign FLASH_ADDR = fl_addr;
  assign MODE_PROG = mode_r;
  assign LOAD_DONE = done_r;
  // Span table base, 176 entries, for the temperature-indexed lookup.
  assign SPAN_DAC_IDX_BASE = {5'h00, pumsa_pkg::FL_SPAN_LUT};
endmodule

//--- bench/pumsa_flash_model.sv
// Behavioural model of the flash array that the autoload sequencer reads.
`timescale 1ns/1ps
module pumsa_flash_model (
  input wire logic blank,
  input wire logic [10:0] addr,
  output logic [7:0] data
);
  logic [7:0] mem [2048];
  // ==========
  // Read path
  // An erased array reads all ones, or else the bytes left by the host's programming pass.
  assign data = blank ? 8'hFF : mem[addr];
endmodule

//--- bench/pumsa_assertions.sv
// Port checker for the power-up mode select block.
`timescale 1ns/1ps
module pumsa_chk (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic MODE_PROG,
  input wire logic LOAD_DONE,
  input wire logic [15:0] SPAN_DAC_IDX_BASE
);
  logic req;
  logic left_r;
  logic left_nxt;
  logic prog_q_r;
  logic prog_q_nxt;
  // ==========
  // Helper state
  // Sticky flag that remembers a fall of the mode, so a later rise is caught.
  assign req = AVS_READ || AVS_WRITE;
  always_comb begin
    left_nxt = left_r || (prog_q_r && !MODE_PROG);
    prog_q_nxt = MODE_PROG;
  end
  // Registers of the helper; reset clears them with the design.
  always_ff @(posedge REF_CLK) begin
    left_r <= SRST ? 1'h0 : left_nxt;
    prog_q_r <= SRST ? 1'h0 : prog_q_nxt;
  end
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);
  // ==========
  // Properties
  a_answer_next: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer held too long");
  a_idle_wait: assert property (!req |=> AVS_WAITREQUEST)
    else $error("answer without request");
  a_unmapped_zero: assert property (AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS[1:0] != 2'h0
    |=> AVS_READDATA == 32'h0000_0000) else $error("unmapped read not zero");
  a_exit_cause: assert property ($fell(MODE_PROG) |-> $past(AVS_WRITE) ||
    $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3)) else $error("mode left without a write");
  a_left_stays: assert property (left_r |-> !MODE_PROG)
    else $error("mode came back after leaving");
  a_done_holds: assert property (LOAD_DONE |=> LOAD_DONE)
    else $error("load done dropped");
  a_idx_base: assert property (!$past(SRST) |-> SPAN_DAC_IDX_BASE == 16'h0010)
    else $error("table base wrong");
  c_enter_prog: cover property ($rose(MODE_PROG));
  c_leave_prog: cover property ($fell(MODE_PROG));
  c_unmapped: cover property (AVS_READ && AVS_ADDRESS[1:0] != 2'h0);
endmodule
bind pumsa_top pumsa_chk chk_u (.REF_CLK(REF_CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .MODE_PROG(MODE_PROG), .LOAD_DONE(LOAD_DONE),
  .SPAN_DAC_IDX_BASE(SPAN_DAC_IDX_BASE));

//--- bench/testbench.sv
// Self-checking bench for the power-up mode select block.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("Error %0t: value %h expected %h", $time, a, b); end end
module testbench;
  logic clk = 1'h0, srst = 1'h1, rd = 1'h0, wr = 1'h0, blank = 1'h0, seen = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, q, rdata;
  logic wreq, mode, done;
  logic [10:0] fa;
  logic [7:0] fd, cfg, cv;
  logic [15:0] base;
  int mismatches = 0, compares = 0;
  // ==========
  // Clock and instances
  initial begin
    forever #12.5 clk = ~clk;
  end
  pumsa_top dut_u (.REF_CLK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .FLASH_ADDR(fa), .FLASH_DATA(fd), .FLASH_BLANK(blank), .MODE_PROG(mode),
    .LOAD_DONE(done), .SPAN_DAC_IDX_BASE(base));
  pumsa_flash_model fl_u (.blank(blank), .addr(fa), .data(fd));
  // A fetch of the last calibration byte shows that the autoload walked the whole set.
  always @(posedge clk) begin
    if (fa === 11'h006) seen <= 1'h1;
  end
  // One bus cycle; the request holds until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    rd <= ~w;
    wr <= w;
    wdata <= d;
    @(posedge clk);
    while (wreq !== 1'h0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    if (n == 50) begin
      mismatches++;
      $display("Error %0t: bus answer timed out", $time);
    end
    @(posedge clk);
  endtask
  // Power-up: store the config word, then hold reset for eight cycles.
  task automatic pu(input logic [7:0] c, input logic b);
    fl_u.mem[0] = c;
    blank <= b;
    srst <= 1'h1;
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    seen <= 1'h0;
    @(posedge clk);
  endtask
  // Poll the status state field under a bounded count of reads.
  task automatic poll(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    do begin
      bus(1'h0, pumsa_pkg::OFF_STATUS, 32'h0000_0000);
      n++;
    end while (q[5:3] !== s && n < lim);
    if (q[5:3] !== s) begin
      mismatches++;
      $display("Error %0t: state %h not reached", $time, s);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog: the scenarios need under two thousand cycles; a hang ends here.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
  // ==========
  // Scenarios
  initial begin
    void'($urandom(8));
    for (int i = 0; i < 2048; i++) fl_u.mem[i] = 8'($urandom);
    // Erased flash: the factory word picks programming without control words.
    pu(8'h00, 1'h1);
    poll(pumsa_pkg::ST_PROG, 2000);
    `CHK(mode, 1'h1)
    bus(1'h0, pumsa_pkg::OFF_CWORD, 32'h0000_0000);
    `CHK(q[7:0], pumsa_pkg::PCW_FACTORY)
    bus(1'h0, 4'h6, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    // Shortest wait and no words: analog is chosen, late words must not change it.
    cfg = {1'h0, 3'($urandom_range(6)), 4'h0};
    pu(cfg, 1'h0);
    poll(pumsa_pkg::ST_ANALOG, 1000);
    `CHK(q[5:3], pumsa_pkg::ST_ANALOG)
    `CHK({done, seen, mode}, 3'h6)
    `CHK(base, 16'(pumsa_pkg::FL_SPAN_LUT))
    // Each register holds its flash byte; a direct write outside programming is refused.
    for (int i = 0; i < pumsa_pkg::NUM_CAL_REGS; i++) begin
      bus(1'h1, pumsa_pkg::OFF_CAL_SEL, {16'h0000, 8'($urandom), 5'h00, 3'(i)});
      bus(1'h0, pumsa_pkg::OFF_CAL_SEL, 32'h0000_0000);
      `CHK(q, {21'h00_0000, 3'(i), fl_u.mem[int'(pumsa_pkg::FL_CAL_ADDR) + i]})
    end
    repeat (8) bus(1'h1, pumsa_pkg::OFF_CWORD, 32'h0000_005A);
    `CHK(mode, 1'h0)
    // Repeat codes 0 to 6: one word short keeps waiting, the next one enters programming; code 7 forces programming.
    for (int r = 0; r < 8; r++) begin
      cfg = {1'h0, 3'(r), 4'($urandom_range(15, 12))};
      pu(cfg, 1'h0);
      if (r == 7) begin
        poll(pumsa_pkg::ST_PROG, 2000);
        // Even when forced, the host opens the session with an initialization byte.
        bus(1'h1, pumsa_pkg::OFF_CWORD, 32'h0000_005A);
      end else begin
        poll(pumsa_pkg::ST_WAIT, 2000);
        // A word of the wrong value must not count towards the repeat field.
        bus(1'h1, pumsa_pkg::OFF_CWORD, 32'h0000_00A5);
        repeat (r) bus(1'h1, pumsa_pkg::OFF_CWORD, 32'h0000_005A);
        repeat (2) @(posedge clk);
        `CHK(mode, 1'h0)
        bus(1'h1, pumsa_pkg::OFF_CWORD, 32'h0000_005A);
        repeat (4) @(posedge clk);
      end
      `CHK(mode, 1'h1)
      bus(1'h0, pumsa_pkg::OFF_CWORD, 32'h0000_0000);
      `CHK(q[7:0], cfg)
      cv = 8'($urandom);
      bus(1'h1, pumsa_pkg::OFF_CAL_SEL, {16'h0000, cv, 5'h00, 3'(r % 6)});
      bus(1'h0, pumsa_pkg::OFF_CAL_SEL, 32'h0000_0000);
      `CHK(q[10:0], {3'(r % 6), cv})
      bus(1'h1, pumsa_pkg::OFF_CTRL, 32'h0000_0001);
      repeat (4) @(posedge clk);
      `CHK(mode, 1'h0)
    end
    summarize();
  end
endmodule
